//--- reset_domain_distribution.sv
// Reset distribution: maps reset sources onto the logic domains they clear.
// How it works
// - Power-good, fundamental and in-band resets clear link, datapath and MAC logic; memories clear on the first two, not on in-band.
// - Interrupt and statistics registers clear on common resets, D3hot-to-D0, FLR, port reset.
// - Wake status and management unit reset only by power-good.
// - Wake control and wake context reset by power-good, in-band reset or missing auxiliary power.
// - Without auxiliary power the wake context resets, so PME bits read zero.
// - Wake context holds PME enable, PME status, aux enable, requester id and shadows.
// - MSI-X state resets on D3hot-to-D0 and FLR, never on port software reset.
// - Port reset clears datapath and queues but not DMA; D3hot and FLR also clear DMA.
// - Pin directions, energy, optical, interface, outer tag, LED, flash access: power-good only.
// - Each non-volatile memory read outside power-good reset reloads the power-good-only configuration fields.
// - Auxiliary power detected bit clears only on power-good or fundamental reset.
// - Memory request and grant handshake fields reset only by power-good and fundamental.
// - DMA misc and parity control clear only on power-good, fundamental or device reset.
// - Packet buffer contents clear with every reset that clears on-die memories except firmware reset.
// - Multicast, filter, wake packet and ring base tables keep contents through all resets.
// - Transmit data lines are zero while port or device software reset is active.
// - Device software reset requests a reload of function sections from memory.
// - After any PHY reset the management unit configures the PHY before use.
// - In-band reset fires on a physical-layer reset message or link fallback to detect.
`timescale 1ns/100ps
`default_nettype none

module reset_domain_distribution (
    input  wire logic                                  clk,
    input  wire logic                                  rst,
    input  wire logic                                  power_good_reset,
    input  wire logic                                  fundamental_reset_n,
    input  wire logic                                  link_reset_message,
    input  wire logic                                  link_fell_to_detect,
    input  wire logic                                  firmware_reset,
    input  wire logic                                  d3hot_to_d0,
    input  wire logic                                  function_level_reset,
    input  wire logic                                  port_soft_reset,
    input  wire logic                                  device_soft_reset,
    input  wire logic                                  eeprom_reset,
    input  wire logic                                  phy_reset,
    input  wire logic                                  aux_power_present,
    input  wire logic                                  aux_power_detect_in,
    input  wire logic                                  nvm_read_done,
    input  wire logic [reset_map_pkg::CFG_WIDTH-1:0]   nvm_config,
    input  wire logic                                  phy_config_done,
    input  wire logic [7:0]                            tx_data_in,
    output logic      [7:0]                            tx_data_out,
    output reset_map_pkg::domains_type                 domain_reset,
    output reset_map_pkg::sources_type                 source_active,
    output logic                                       in_band_reset,
    output logic                                       nvm_reload_request,
    output logic                                       phy_config_request,
    output logic                                       phy_ready,
    output logic [reset_map_pkg::CFG_WIDTH-1:0]        pg_only_config,
    output logic                                       aux_power_detected,
    output logic                                       wake_context_clear,
    output logic                                       packet_buffer_clear,
    output logic                                       reset_done_flag
);

    // Three-stage synchronisers for all asynchronous reset sources.
    localparam int unsigned N_SRC = 11;
    logic [N_SRC-1:0] raw;
    logic [N_SRC-1:0] s1;
    logic [N_SRC-1:0] s2;
    logic [N_SRC-1:0] s3;
    logic [N_SRC-1:0] filt;
    logic [N_SRC-1:0] next_filt;

    assign raw = {power_good_reset, ~fundamental_reset_n, link_reset_message,
                  link_fell_to_detect, firmware_reset, d3hot_to_d0,
                  function_level_reset, port_soft_reset, device_soft_reset,
                  eeprom_reset, phy_reset};

    // A change is accepted only when the second and third stages agree.
    always_comb begin
        for (int i = 0; i < N_SRC; i++) begin
            next_filt[i] = (s2[i] == s3[i]) ? s3[i] : filt[i];
        end
    end

    // Synchroniser stages run through reset so power-good is seen while it is held.
    always_ff @(posedge clk) begin
        s1 <= raw;
        s2 <= s1;
        s3 <= s2;
        if (rst) begin
            filt <= '0;
        end else begin
            filt <= next_filt;
        end
    end

    reset_map_pkg::sources_type src;
    always_comb begin
        src.power_good  = filt[10];
        src.fundamental = filt[9];
        src.in_band     = filt[8] | filt[7];
        src.firmware    = filt[6];
        src.d3hot_to_d0 = filt[5];
        src.flr         = filt[4];
        src.port_soft   = filt[3];
        src.device_soft = filt[2];
        src.eeprom      = filt[1];
        src.phy         = filt[0];
    end

    // Combined requests per domain before release stretching.
    reset_map_pkg::domains_type req;
    logic common;
    logic per_func;
    always_comb begin
        common             = src.power_good | src.fundamental | src.in_band;
        per_func           = src.d3hot_to_d0 | src.flr;
        req.link           = common;
        req.datapath       = common | per_func | src.port_soft;
        req.func_irq_stats = common | per_func | src.port_soft;
        req.wake_status    = src.power_good;
        req.wake_control   = src.power_good | src.in_band | ~aux_power_present;
        req.msix           = common | per_func;
        req.dma            = common | per_func;
        req.dma_ctrl_regs  = src.power_good | src.fundamental | src.device_soft;
        req.pg_only        = src.power_good;
        req.aux_detect     = src.power_good | src.fundamental;
        req.strap          = src.power_good | src.fundamental;
        req.mem_config     = src.power_good | src.fundamental | src.firmware
                             | per_func | src.port_soft;
    end

    // Each domain reset holds for a fixed stretch after its last request.
    localparam int unsigned N_DOM = 12;
    logic [N_DOM-1:0] req_vec;
    logic [2:0]       hold [N_DOM];
    logic [2:0]       next_hold [N_DOM];
    logic [N_DOM-1:0] dom;
    logic [N_DOM-1:0] next_dom;
    assign req_vec = req;

    always_comb begin
        for (int i = 0; i < N_DOM; i++) begin
            if (req_vec[i]) begin
                next_hold[i] = reset_map_pkg::RELEASE_LAST;
                next_dom[i]  = 1'b1;
            end else if (hold[i] != 3'h0) begin
                next_hold[i] = hold[i] - 3'h1;
                next_dom[i]  = 1'b1;
            end else begin
                next_hold[i] = 3'h0;
                next_dom[i]  = 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < N_DOM; i++) begin
            if (rst) begin
                hold[i] <= reset_map_pkg::RELEASE_LAST;
                dom[i]  <= 1'b1;
            end else begin
                hold[i] <= next_hold[i];
                dom[i]  <= next_dom[i];
            end
        end
    end
    assign domain_reset = dom;

    // Power-good-only configuration, aux detect, reload and PHY sequencing.
    typedef enum {RL_IDLE, RL_WAIT} reload_state_type;
    typedef enum {PH_READY, PH_RESET, PH_CONFIG} phy_state_type;
    reload_state_type                        rl;
    reload_state_type                        next_rl;
    phy_state_type                           ph;
    phy_state_type                           next_ph;
    logic [reset_map_pkg::CFG_WIDTH-1:0]     cfg;
    logic [reset_map_pkg::CFG_WIDTH-1:0]     next_cfg;
    logic                                    aux;
    logic                                    next_aux;
    logic                                    dev_soft_d;
    logic                                    done;
    logic                                    next_done;
    logic [7:0]                              txd;
    logic [7:0]                              next_txd;

    always_comb begin
        next_cfg = cfg;
        if (domain_reset.pg_only) begin
            next_cfg = reset_map_pkg::CFG_RESET;
        end else if (nvm_read_done) begin
            next_cfg = nvm_config;
        end
        next_aux = domain_reset.aux_detect ? 1'b0 : (aux | aux_power_detect_in);
        next_rl = rl;
        case (rl)
            RL_IDLE: begin
                if (src.device_soft && !dev_soft_d) begin
                    next_rl = RL_WAIT;
                end
            end
            RL_WAIT: begin
                // A new request that lands with the completion keeps the reload pending.
                if (nvm_read_done && !(src.device_soft && !dev_soft_d)) begin
                    next_rl = RL_IDLE;
                end
            end
            default: next_rl = RL_IDLE;
        endcase
        next_ph = ph;
        case (ph)
            PH_READY: begin
                if (src.phy) begin
                    next_ph = PH_RESET;
                end
            end
            PH_RESET: begin
                if (!src.phy) begin
                    next_ph = PH_CONFIG;
                end
            end
            PH_CONFIG: begin
                if (src.phy) begin
                    next_ph = PH_RESET;
                end else if (phy_config_done) begin
                    next_ph = PH_READY;
                end
            end
            default: next_ph = PH_RESET;
        endcase
        // Done needs every domain released and no reload outstanding.
        next_done = (dom == '0) && (rl == RL_IDLE) && !(next_rl == RL_WAIT);
        next_txd = (src.port_soft || src.device_soft) ? 8'h00 : tx_data_in;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cfg        <= reset_map_pkg::CFG_RESET;
            aux        <= 1'b0;
            rl         <= RL_IDLE;
            ph         <= PH_CONFIG;
            dev_soft_d <= 1'b0;
            done       <= 1'b0;
            txd        <= 8'h00;
        end else begin
            cfg        <= next_cfg;
            aux        <= next_aux;
            rl         <= next_rl;
            ph         <= next_ph;
            dev_soft_d <= src.device_soft;
            done       <= next_done;
            txd        <= next_txd;
        end
    end

    // Tables without defaults (multicast, filters, wake packet, ring bases) get no reset.
    assign source_active       = src;
    assign in_band_reset       = src.in_band;
    assign nvm_reload_request  = (rl == RL_WAIT);
    assign phy_config_request  = (ph == PH_CONFIG);
    assign phy_ready           = (ph == PH_READY);
    assign pg_only_config      = cfg;
    assign aux_power_detected  = aux;
    assign wake_context_clear  = dom[7];
    assign packet_buffer_clear = dom[10];
    assign reset_done_flag     = done;
    assign tx_data_out         = txd;

    // Checks on the design's own outputs.
    wake_pg_only_a: assert property (@(posedge clk) disable iff (rst)
        $rose(domain_reset.wake_status) |-> $past(src.power_good))
        else $error("Wake status reset by a non power-good source.");

    msix_port_a: assert property (@(posedge clk) disable iff (rst)
        $rose(domain_reset.msix) |-> $past(src.d3hot_to_d0 || src.flr || common))
        else $error("MSI-X state reset by a source outside its mapping.");

    tx_zero_a: assert property (@(posedge clk) disable iff (rst)
        src.port_soft || src.device_soft |=> tx_data_out == 8'h00)
        else $error("Transmit data not zero during software reset.");

    aux_clear_a: assert property (@(posedge clk) disable iff (rst)
        aux_power_detected && !domain_reset.aux_detect |=> aux_power_detected)
        else $error("Aux detected bit cleared without its reset.");

    sequence dev_soft_rise_s;
        src.device_soft && !dev_soft_d;
    endsequence
    reload_req_a: assert property (@(posedge clk) disable iff (rst)
        dev_soft_rise_s |=> nvm_reload_request)
        else $error("Device reset did not request a reload.");

    done_order_a: assert property (@(posedge clk) disable iff (rst)
        reset_done_flag |-> $past(dom == '0) && !nvm_reload_request)
        else $error("Reset done raised early.");

    sequence phy_release_s;
        src.phy ##1 !src.phy;
    endsequence
    phy_cfg_a: assert property (@(posedge clk) disable iff (rst)
        phy_release_s |=> phy_config_request)
        else $error("PHY used without configuration.");

    sequence link_release_s;
        req.link ##1 !req.link;
    endsequence
    dom_hold_a: assert property (@(posedge clk) disable iff (rst)
        link_release_s |-> domain_reset.link [*4])
        else $error("Link domain released before its stretch.");

    cfg_reload_a: assert property (@(posedge clk) disable iff (rst)
        nvm_read_done && !domain_reset.pg_only |=> pg_only_config == $past(nvm_config))
        else $error("Configuration not reloaded from memory.");

    pg_cfg_a: assert property (@(posedge clk) disable iff (rst)
        domain_reset.pg_only |=> pg_only_config == reset_map_pkg::CFG_RESET)
        else $error("Power-good-only configuration not returned to its reset value.");

    wake_ctx_aux_a: assert property (@(posedge clk) disable iff (rst)
        !aux_power_present |=> wake_context_clear)
        else $error("Wake context not held while auxiliary power is absent.");

    wake_ctl_a: assert property (@(posedge clk) disable iff (rst)
        $rose(domain_reset.wake_control)
            |-> $past(src.power_good || src.in_band || !aux_power_present))
        else $error("Wake control reset by a per-function source.");

    strap_rise_a: assert property (@(posedge clk) disable iff (rst)
        $rose(domain_reset.strap) |-> $past(src.power_good || src.fundamental))
        else $error("Strapping state reset by a source outside its mapping.");

    dma_regs_a: assert property (@(posedge clk) disable iff (rst)
        $rose(domain_reset.dma_ctrl_regs)
            |-> $past(src.power_good || src.fundamental || src.device_soft))
        else $error("DMA control registers reset by a source outside their mapping.");

    dma_port_a: assert property (@(posedge clk) disable iff (rst)
        $rose(domain_reset.dma) |-> $past(common || per_func))
        else $error("DMA logic reset by the port software reset.");

    datapath_port_a: assert property (@(posedge clk) disable iff (rst)
        src.port_soft |=> domain_reset.datapath)
        else $error("Data path not reset by the port software reset.");

    link_common_a: assert property (@(posedge clk) disable iff (rst)
        common |=> domain_reset.link)
        else $error("Link logic not reset by a common reset.");

    buf_flr_a: assert property (@(posedge clk) disable iff (rst)
        src.flr |=> packet_buffer_clear)
        else $error("Packet buffers not cleared on function level reset.");

endmodule : reset_domain_distribution

`default_nettype wire

//--- reset_map_pkg.sv
// Package holding reset source bundles, domain bundles and timing constants for reset distribution.
package reset_map_pkg;

    // Release stretch applied to every domain reset, in cycles.
    localparam int unsigned RELEASE_CYCLES = 4;
    localparam logic [2:0]  RELEASE_LAST   = 3'h3;
    // Configuration field width reloaded from non-volatile memory.
    localparam int unsigned CFG_WIDTH      = 16;
    localparam logic [15:0] CFG_RESET      = 16'h0000;
    // Synchroniser depth for asynchronous sources.
    localparam int unsigned SYNC_DEPTH     = 3;

    typedef struct packed {
        logic power_good;
        logic fundamental;
        logic in_band;
        logic firmware;
        logic d3hot_to_d0;
        logic flr;
        logic port_soft;
        logic device_soft;
        logic eeprom;
        logic phy;
    } sources_type;

    typedef struct packed {
        logic link;
        logic datapath;
        logic func_irq_stats;
        logic wake_status;
        logic wake_control;
        logic msix;
        logic dma;
        logic dma_ctrl_regs;
        logic pg_only;
        logic aux_detect;
        logic strap;
        logic mem_config;
    } domains_type;

endpackage : reset_map_pkg

//--- reset_far_side_model.sv
// Far-side model: memory loader and PHY configuration engine answering the reset block.
`timescale 1ns/100ps
`default_nettype none

module reset_far_side_model (
    input  wire logic        clk,
    input  wire logic        nvm_reload_request,
    input  wire logic        phy_config_request,
    input  wire logic [15:0] load_value,
    input  wire logic [3:0]  delay,
    output logic             nvm_read_done,
    output logic [15:0]      nvm_config,
    output logic             phy_config_done
);
    // Load data is only meaningful with the done pulse, so it is inverted otherwise.
    initial begin
        nvm_read_done = 1'b0;
        nvm_config = 16'hFFFF;
        forever begin
            @(posedge clk);
            if (nvm_reload_request === 1'b1) begin
                repeat (delay) @(posedge clk);
                nvm_config <= load_value;
                nvm_read_done <= 1'b1;
                @(posedge clk);
                nvm_read_done <= 1'b0;
                nvm_config <= ~load_value;
                @(posedge clk);
            end
        end
    end

    initial begin
        phy_config_done = 1'b0;
        forever begin
            @(posedge clk);
            if (phy_config_request === 1'b1) begin
                repeat (delay) @(posedge clk);
                phy_config_done <= 1'b1;
                @(posedge clk);
                phy_config_done <= 1'b0;
                @(posedge clk);
            end
        end
    end
endmodule : reset_far_side_model
`default_nettype wire

//--- reset_domain_distribution_tb.sv
// Self-checking bench for the reset distribution block with a source-to-domain reference table.
`timescale 1ns/100ps
`default_nettype none

module reset_domain_distribution_tb;
    logic                       clk;
    logic                       rst;
    logic [10:0]                src;
    logic                       aux_present;
    logic                       aux_detect_in;
    logic [7:0]                 tx_in;
    logic [7:0]                 tx_out;
    logic                       nvm_done;
    logic [15:0]                nvm_cfg;
    logic                       phy_done;
    logic [15:0]                load_value;
    logic [3:0]                 delay;
    reset_map_pkg::domains_type dom;
    logic                       in_band;
    logic                       reload_req;
    logic                       phy_req;
    logic                       phy_ready;
    logic                       aux_seen;
    logic                       ctx_clear;
    logic                       buf_clear;
    logic                       done_flag;
    logic [15:0]                cfg_out;
    int                         err_count;
    int                         cmp_count;
    int                         reload_cnt = 0;
    logic [15:0]                cfg_saved;
    // Index order: phy, eeprom, device, port, flr, d3hot, firmware, fell, message, fundamental, pg.
    logic [11:0] exp_tab [11] = '{12'h000, 12'h000, 12'h010, 12'h601, 12'h661, 12'h661,
                                  12'h001, 12'hEA0, 12'hEA0, 12'hE37, 12'hFBF};
    // Bits the mapping leaves open for a source are masked rather than guessed.
    logic [11:0] care_tab [11] = '{12'hFFF, 12'hFFF, 12'h19E, 12'hFFF, 12'hFFF, 12'hFFF,
                                   12'hFFF, 12'hFBF, 12'hFBF, 12'hFBF, 12'hFBF};

    reset_domain_distribution DUT (
        .clk(clk), .rst(rst), .power_good_reset(src[10]), .fundamental_reset_n(~src[9]),
        .link_reset_message(src[8]), .link_fell_to_detect(src[7]), .firmware_reset(src[6]),
        .d3hot_to_d0(src[5]), .function_level_reset(src[4]), .port_soft_reset(src[3]),
        .device_soft_reset(src[2]), .eeprom_reset(src[1]), .phy_reset(src[0]),
        .aux_power_present(aux_present), .aux_power_detect_in(aux_detect_in),
        .nvm_read_done(nvm_done), .nvm_config(nvm_cfg), .phy_config_done(phy_done),
        .tx_data_in(tx_in), .tx_data_out(tx_out), .domain_reset(dom), .source_active(),
        .in_band_reset(in_band), .nvm_reload_request(reload_req),
        .phy_config_request(phy_req), .phy_ready(phy_ready), .pg_only_config(cfg_out),
        .aux_power_detected(aux_seen), .wake_context_clear(ctx_clear),
        .packet_buffer_clear(buf_clear), .reset_done_flag(done_flag));

    // The reload request may finish long before a check looks, so its rises are counted.
    always @(posedge reload_req) reload_cnt++;

    reset_far_side_model far_side (
        .clk(clk), .nvm_reload_request(reload_req), .phy_config_request(phy_req),
        .load_value(load_value), .delay(delay), .nvm_read_done(nvm_done),
        .nvm_config(nvm_cfg), .phy_config_done(phy_done));

    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic hit(input int idx);
        logic [11:0] e;
        logic [11:0] c;
        int          n0;
        e = exp_tab[idx];
        c = care_tab[idx];
        n0 = reload_cnt;
        @(posedge clk) src[idx] <= 1'b1;
        repeat (12) @(posedge clk);
        @(negedge clk);
        check("domains", {4'h0, e & c}, {4'h0, dom & c});
        if (idx == 3 || idx == 2) check("tx zero", 16'h0000, {8'h00, tx_out});
        check("reload", (idx == 2) ? 16'h0001 : 16'h0000, 16'(reload_cnt - n0));
        if (idx == 0) check("phy held", 16'h0000, {15'h0, phy_ready});
        if (e != 12'h000) check("done low", 16'h0000, {15'h0, done_flag});
        if (idx == 7 || idx == 8) check("in band", 16'h0001, {15'h0, in_band});
        if (idx == 4) check("buffers", 16'h0001, {15'h0, buf_clear});
        @(posedge clk) src[idx] <= 1'b0;
        repeat (40) @(posedge clk);
        @(negedge clk);
        check("released", 16'h0000, {4'h0, dom});
        check("done high", 16'h0001, {15'h0, done_flag});
        check("phy ready", 16'h0001, {15'h0, phy_ready});
        if (idx == 2) check("config", load_value, cfg_out);
        $display("test source %0d finished", idx);
    endtask : hit

    task automatic tx_pass();
        logic [7:0] v;
        v = 8'($urandom);
        @(posedge clk) tx_in <= v;
        @(posedge clk);
        @(negedge clk);
        check("tx pass", {8'h00, v}, {8'h00, tx_out});
    endtask : tx_pass

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #200us;
        err_count++;
        test_done();
    end

    initial begin
        rst = 1'b1;
        src = 11'h000;
        aux_present = 1'b1;
        aux_detect_in = 1'b0;
        tx_in = 8'h00;
        load_value = 16'h0000;
        delay = 4'h1;
        err_count = 0;
        cmp_count = 0;
        void'($urandom(32'h95b5081a));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (40) @(posedge clk);
        @(posedge clk) aux_detect_in <= 1'b1;
        @(posedge clk) aux_detect_in <= 1'b0;
        for (int i = 0; i < 11; i++) begin
            @(posedge clk) load_value <= 16'($urandom);
            delay <= 4'($urandom_range(1, 8));
            hit(i);
            if (i == 2) cfg_saved = load_value;
            if (i == 3) check("aux kept", 16'h0001, {15'h0, aux_seen});
            if (i == 9) check("aux cleared", 16'h0000, {15'h0, aux_seen});
            if (i == 9) check("cfg kept", cfg_saved, cfg_out);
            if (i == 10) check("cfg pg", reset_map_pkg::CFG_RESET, cfg_out);
            tx_pass();
        end
        // Missing auxiliary power holds the wake context in reset for as long as it lasts.
        @(posedge clk) aux_present <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        check("wake ctx", 16'h0001, {15'h0, ctx_clear});
        check("wake ctl", 16'h0001, {15'h0, dom.wake_control});
        check("wake stat", 16'h0000, {15'h0, dom.wake_status});
        @(posedge clk) aux_present <= 1'b1;
        repeat (20) @(posedge clk);
        @(negedge clk);
        check("wake ctx off", 16'h0000, {15'h0, ctx_clear});
        $display("test aux power finished");
        test_done();
    end
endmodule : reset_domain_distribution_tb
`default_nettype wire
